// ==== design/psc_map.svh ====
// Purpose: Offsets, field positions, reset values and counts of the clock controller
// Assumes: Word offsets (byte address bits 7:2) on a 32-bit classic Wishbone bus
// Notes:   Definitions only
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

`define PSC_OSC_OFS     6'h00
`define PSC_RST_OFS     6'h01
`define PSC_DIV_OFS     6'h02
`define PSC_MD_OFS      6'h03
`define PSC_SIDL_OFS    6'h04
`define PSC_STAT_OFS    6'h05

`define PSC_NOSC_LSB    8
`define PSC_COSC_LSB    12
`define PSC_VMAIN_BIT   8
`define PSC_VFLASH_BIT  11
`define PSC_DOZE_ENABLE_BIT   11
`define PSC_DOZE_LSB    12
`define PSC_ROI_BIT     15

`define PSC_NOSC_RST    3'h0
`define PSC_DOZE_RST    3'h0
`define PSC_MD_RST      16'h0000
`define PSC_SIDL_RST    16'h0000

`define PSC_WAKE_CYC    2'h3

`endif

// ==== design/psc_pkg.sv ====
// Purpose: Types shared by the clock controller and its bench
// Assumes: psc_map.svh holds the register numbers; mode codes are set here
// Notes:   Mode codes are Gray along run, enter, idle, sleep, wake
package psc_pkg;

    typedef enum logic [2:0] {
        MODE_RUN   = 3'h0,
        MODE_ENTER = 3'h1,
        MODE_IDLE  = 3'h3,
        MODE_SLEEP = 3'h2,
        MODE_WAKE  = 3'h6
    } pm_mode_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;

    typedef struct packed {
        pm_mode_t    mode;
        logic        go_sleep;
        logic        int_held;
        logic [1:0]  wake_cnt;
        logic [2:0]  new_osc;
        logic [2:0]  cur_osc;
        logic        vmain;
        logic        vflash;
        logic        recover_on_interrupt;
        logic [2:0]  doze;
        logic        doze_enable;
        logic [6:0]  doze_cnt;
        logic [15:0] md;
        logic [15:0] md_live;
        logic [15:0] sidl;
        logic [15:0] pclk;
        logic        cpu_en;
        logic        wdt_clr;
        logic [1:0]  wdt_sync;
        logic        ack;
        logic [31:0] rdat;
    } ctl_state_t;

endpackage : psc_pkg

// ==== design/power_saving_clock_controller.sv ====
// Purpose: Sleep, Idle, Doze and module-disable clock control
// Assumes: Core and peripherals gate their clocks with these enables
// Notes:   Enables come from flops, so clock gates see no short pulse
//
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "psc_map.svh"

module power_saving_clock_controller (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire psc_pkg::wb_req_t  wb_req,
    output var  psc_pkg::wb_rsp_t  wb_rsp,
    input  wire logic              psave_valid,
    input  wire logic              psave_idle,
    input  wire logic              int_request,
    input  wire logic              wdt_timeout,
    input  wire logic              wdt_enable,
    input  wire logic              failsafe_clock_monitor_enable,
    input  wire logic              clock_lock,
    input  wire logic [15:0]       periph_present,
    output logic                   cpu_clk_en,
    output logic [15:0]            periph_clk_en,
    output logic [15:0]            periph_access_en,
    output logic [2:0]             sys_osc_select,
    output logic                   sys_osc_enable,
    output logic                   failsafe_clock_monitor_active,
    output logic                   low_power_rc_clock_run,
    output logic                   wdt_clear,
    output logic                   main_regulator_standby,
    output logic                   flash_regulator_standby
);
    import psc_pkg::*;

    ctl_state_t st;
    ctl_state_t next_st;

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] wr_v,
                                            input logic [3:0]  sel);
        merge16 = old_v;
        if (sel[0]) begin
            merge16[7:0] = wr_v[7:0];
        end
        if (sel[1]) begin
            merge16[15:8] = wr_v[15:8];
        end
    endfunction : merge16

    // Divide mask for a doze ratio of 2**code
    function automatic logic [6:0] doze_mask(input logic [2:0] code);
        doze_mask = 7'((8'h01 << code) - 8'h01);
    endfunction : doze_mask

    logic        bus_req;
    logic        bus_wr;
    logic [5:0]  reg_idx;
    logic [15:0] osc_wr;
    logic [15:0] rst_wr;
    logic [15:0] div_wr;
    logic        wake_event;
    logic        in_sleep;
    logic        in_idle;

    assign bus_req  = wb_req.cyc && wb_req.stb && !st.ack;
    assign bus_wr   = bus_req && wb_req.we;
    assign reg_idx  = wb_req.adr[7:2];
    assign in_sleep = (st.mode == MODE_SLEEP);
    assign in_idle  = (st.mode == MODE_IDLE);
    // Synced watchdog level only; the first stage is never read here
    assign wake_event = int_request || st.int_held || st.wdt_sync[1];

    always_comb begin
        osc_wr = {1'b0, st.cur_osc, 1'b0, st.new_osc, 8'h00};
        rst_wr = 16'h0000;
        div_wr = 16'h0000;
        osc_wr = merge16(osc_wr, wb_req.dat, wb_req.sel);
        rst_wr[`PSC_VMAIN_BIT]  = st.vmain;
        rst_wr[`PSC_VFLASH_BIT] = st.vflash;
        rst_wr = merge16(rst_wr, wb_req.dat, wb_req.sel);
        div_wr[`PSC_ROI_BIT]    = st.recover_on_interrupt;
        div_wr[`PSC_DOZE_ENABLE_BIT]  = st.doze_enable;
        div_wr[`PSC_DOZE_LSB +: 3] = st.doze;
        div_wr = merge16(div_wr, wb_req.dat, wb_req.sel);
    end

    always_comb begin
        next_st = st;
        next_st.wdt_sync = {st.wdt_sync[0], wdt_timeout};
        next_st.wdt_clr  = 1'b0;
        next_st.ack      = wb_req.cyc && wb_req.stb && !st.ack;
        next_st.rdat     = 32'h0000_0000;

        // Register writes
        if (bus_wr) begin
            case (reg_idx)
                `PSC_OSC_OFS: begin
                    if (!clock_lock) begin
                        next_st.new_osc = osc_wr[`PSC_NOSC_LSB +: 3];
                    end
                end
                `PSC_RST_OFS: begin
                    next_st.vmain  = rst_wr[`PSC_VMAIN_BIT];
                    next_st.vflash = rst_wr[`PSC_VFLASH_BIT];
                end
                `PSC_DIV_OFS: begin
                    next_st.recover_on_interrupt = div_wr[`PSC_ROI_BIT];
                    if (!st.doze_enable) begin
                        next_st.doze = div_wr[`PSC_DOZE_LSB +: 3];
                    end
                    if (next_st.doze != 3'h0) begin
                        next_st.doze_enable = div_wr[`PSC_DOZE_ENABLE_BIT];
                    end else begin
                        next_st.doze_enable = 1'b0;
                    end
                end
                `PSC_MD_OFS: begin
                    next_st.md = merge16(st.md, wb_req.dat, wb_req.sel);
                end
                `PSC_SIDL_OFS: begin
                    next_st.sidl = merge16(st.sidl, wb_req.dat, wb_req.sel);
                end
                default: begin
                end
            endcase
        end

        // Hardware clear beats a software set in the same cycle
        if (st.doze_enable && st.recover_on_interrupt && int_request) begin
            next_st.doze_enable = 1'b0;
        end

        // Register reads; unmapped words read zero
        if (bus_req && !wb_req.we) begin
            case (reg_idx)
                `PSC_OSC_OFS:  next_st.rdat = {16'h0000, 1'b0, st.cur_osc, 1'b0,
                                               st.new_osc, 8'h00};
                `PSC_RST_OFS:  next_st.rdat = {16'h0000, 4'h0, st.vflash, 2'h0,
                                               st.vmain, 8'h00};
                `PSC_DIV_OFS:  next_st.rdat = {16'h0000, st.recover_on_interrupt, st.doze, st.doze_enable,
                                               11'h000};
                `PSC_MD_OFS:   next_st.rdat = {16'h0000, st.md};
                `PSC_SIDL_OFS: next_st.rdat = {16'h0000, st.sidl};
                `PSC_STAT_OFS: next_st.rdat = {24'h000000, st.cpu_en, st.cur_osc,
                                               1'b0, st.mode};
                default:       next_st.rdat = 32'h0000_0000;
            endcase
        end

        // Power mode sequencing
        case (st.mode)
            MODE_RUN: begin
                next_st.cur_osc = st.new_osc;
                next_st.int_held = 1'b0;
                if (psave_valid) begin
                    next_st.mode     = MODE_ENTER;
                    next_st.go_sleep = !psave_idle;
                    next_st.wdt_clr  = wdt_enable;
                end
            end
            MODE_ENTER: begin
                // Wake sources wait until entry is complete
                next_st.int_held = st.int_held || int_request || st.wdt_sync[1];
                next_st.mode = st.go_sleep ? MODE_SLEEP : MODE_IDLE;
            end
            MODE_SLEEP, MODE_IDLE: begin
                if (wake_event) begin
                    next_st.mode     = MODE_WAKE;
                    next_st.int_held = 1'b0;
                    next_st.wake_cnt = 2'h0;
                end
            end
            MODE_WAKE: begin
                if (st.wake_cnt == `PSC_WAKE_CYC - 2'h1) begin
                    next_st.mode = MODE_RUN;
                end else begin
                    next_st.wake_cnt = st.wake_cnt + 2'h1;
                end
            end
            default: begin
                next_st.mode = MODE_RUN;
            end
        endcase

        // CPU enable: one full cycle high or low, never a fraction
        if (st.mode == MODE_RUN && !(psave_valid)) begin
            if (st.doze_enable) begin
                next_st.cpu_en = (st.doze_cnt == 7'h00);
                if (st.doze_cnt == doze_mask(st.doze)) begin
                    next_st.doze_cnt = 7'h00;
                end else begin
                    next_st.doze_cnt = st.doze_cnt + 7'h01;
                end
            end else begin
                next_st.cpu_en   = 1'b1;
                next_st.doze_cnt = 7'h00;
            end
        end else begin
            next_st.cpu_en   = 1'b0;
            next_st.doze_cnt = 7'h00;
        end

        // Peripheral clocks follow the disable bits one cycle later
        // Keyed to the coming mode, so clocks stop with the oscillator
        next_st.md_live = st.md;
        next_st.pclk = periph_present & ~st.md;
        if (next_st.mode == MODE_SLEEP) begin
            next_st.pclk = 16'h0000;
        end else if (next_st.mode == MODE_IDLE) begin
            next_st.pclk = periph_present & ~st.md & ~st.sidl;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st          <= '0;
            st.mode     <= MODE_RUN;
            st.new_osc  <= `PSC_NOSC_RST;
            st.cur_osc  <= `PSC_NOSC_RST;
            st.doze     <= `PSC_DOZE_RST;
            st.md       <= `PSC_MD_RST;
            st.md_live  <= `PSC_MD_RST;
            st.sidl     <= `PSC_SIDL_RST;
            st.pclk     <= 16'h0000;
        end else begin
            st <= next_st;
        end
    end

    assign wb_rsp           = '{ack: st.ack, dat: st.rdat};
    assign cpu_clk_en       = st.cpu_en;
    assign periph_clk_en    = st.pclk;
    assign periph_access_en = periph_present & ~st.md_live;
    assign sys_osc_select   = st.cur_osc;
    assign sys_osc_enable   = !in_sleep;
    assign failsafe_clock_monitor_active = failsafe_clock_monitor_enable && !in_sleep;
    assign low_power_rc_clock_run = wdt_enable || (failsafe_clock_monitor_enable && !in_sleep);
    assign wdt_clear        = st.wdt_clr;
    assign main_regulator_standby  = in_sleep && !st.vmain;
    assign flash_regulator_standby = in_sleep && !st.vflash;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    logic div_write;
    logic osc_write;
    assign div_write = bus_wr && (reg_idx == `PSC_DIV_OFS);
    assign osc_write = bus_wr && (reg_idx == `PSC_OSC_OFS);

    sleep_cpu_off_a: assert property (in_sleep |-> !cpu_clk_en && periph_clk_en == 16'h0000)
        else $error("clock active in sleep");
    sleep_osc_off_a: assert property (in_sleep |-> !sys_osc_enable && !failsafe_clock_monitor_active)
        else $error("oscillator or monitor on in sleep");
    rc_watchdog_a: assert property (wdt_enable |-> low_power_rc_clock_run)
        else $error("rc clock stopped with watchdog on");
    wdt_clear_a: assert property (st.mode == MODE_RUN && psave_valid && wdt_enable |=> wdt_clear ##1 !wdt_clear)
        else $error("watchdog not cleared on entry");
    sleep_osc_hold_a: assert property (in_sleep |=> $stable(sys_osc_select))
        else $error("clock source changed in sleep");
    idle_wake_time_a: assert property (in_idle && int_request && !st.doze_enable |-> !cpu_clk_en [*5] ##1 cpu_clk_en)
        else $error("idle wake timing wrong");
    held_int_wake_a: assert property (st.mode == MODE_ENTER && int_request |=> (in_sleep || in_idle) ##1 st.mode == MODE_WAKE)
        else $error("held interrupt did not wake");
    ratio_lock_a: assert property (div_write && st.doze_enable |=> $stable(st.doze))
        else $error("ratio changed while doze on");
    doze_nonzero_a: assert property (st.doze_enable |-> st.doze != 3'h0)
        else $error("doze enabled at unity ratio");
    roi_clear_a: assert property (st.doze_enable && st.recover_on_interrupt && int_request |=> !st.doze_enable)
        else $error("doze not cleared by interrupt");
    md_delay_a: assert property (st.mode == MODE_RUN && !rst |=> periph_clk_en == (periph_present & ~$past(st.md)))
        else $error("module clock delay wrong");
    idle_stop_a: assert property (in_idle |-> (periph_clk_en & $past(st.sidl)) == 16'h0000)
        else $error("stop-in-idle peripheral clocked");
    osc_lock_a: assert property (osc_write && clock_lock |=> $stable(st.new_osc))
        else $error("locked oscillator select changed");

    sleep_wake_c: cover property (in_sleep ##1 st.mode == MODE_WAKE);
    idle_wake_c: cover property (in_idle ##1 st.mode == MODE_WAKE);
    doze_run_c: cover property (st.doze_enable && st.doze == 3'h7 && cpu_clk_en);
    roi_exit_c: cover property (st.doze_enable && st.recover_on_interrupt && int_request);

endmodule : power_saving_clock_controller

`default_nettype wire

// ==== tb/core_model.sv ====
// Purpose: Core and interrupt logic facing the clock controller
// Assumes: An instruction executes only on a cycle with the CPU clock enabled
// Notes:   Interrupt line is registered, so it lags the request by a cycle
`timescale 1ns/1ps
`default_nettype none

module core_model (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        cpu_clk_en,
    input  wire logic        cmd_go,
    input  wire logic        cmd_idle,
    input  wire logic        irq_in,
    output logic             psave_valid,
    output logic             psave_idle,
    output logic             int_request,
    output logic [15:0]      cpu_ticks
);
    logic pending;
    logic fire;

    // Stalled core cannot issue the instruction
    assign fire = pending & cpu_clk_en & ~psave_valid;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pending     <= 1'b0;
            psave_valid <= 1'b0;
            psave_idle  <= 1'b0;
            int_request <= 1'b0;
            cpu_ticks   <= 16'h0000;
        end else begin
            pending     <= (pending | cmd_go) & ~fire;
            psave_valid <= fire;
            psave_idle  <= fire ? cmd_idle : psave_idle;
            int_request <= irq_in;
            cpu_ticks   <= cpu_ticks + {15'h0000, cpu_clk_en};
        end
    end
endmodule : core_model

`default_nettype wire

// ==== tb/power_saving_clock_controller_bench.sv ====
// Purpose: Self-checking bench for the clock controller
// Assumes: Bus answers one cycle after the taking edge
// Notes:   Outputs sampled at the rising edge, before its updates land
`timescale 1ns/1ps
`default_nettype none

module power_saving_clock_controller_bench;
    import psc_pkg::*;
    localparam logic [15:0] PRESENT = 16'hFF7F;
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    wb_req_t     wb_req  = '0;
    wb_rsp_t     wb_rsp;
    logic        go = 1'b0, idle = 1'b0, irq = 1'b0, wdt_to = 1'b0;
    logic        wdt_en = 1'b0, failsafe_clock_monitor_en = 1'b0, lock = 1'b0;
    logic        psv, psi, intr, cpu_en, osc_en, fs_act, rc_run, wclr, mstb, fstb;
    logic [15:0] pclk, pacc, ticks, t0;
    logic [2:0]  osc_sel;
    logic [31:0] q, pclk_ack;
    int          error_cnt = 0, samples_checked = 0, n, wclr_cnt = 0, w0;

    always #2 ref_clk = ~ref_clk;
    // Count clear pulses so a double pulse is caught too
    always @(posedge ref_clk) if (wclr === 1'b1) wclr_cnt <= wclr_cnt + 1;

    power_saving_clock_controller dut (.ref_clk(ref_clk), .rst(rst), .wb_req(wb_req),
        .wb_rsp(wb_rsp), .psave_valid(psv), .psave_idle(psi), .int_request(intr),
        .wdt_timeout(wdt_to), .wdt_enable(wdt_en), .failsafe_clock_monitor_enable(failsafe_clock_monitor_en),
        .clock_lock(lock), .periph_present(PRESENT), .cpu_clk_en(cpu_en),
        .periph_clk_en(pclk), .periph_access_en(pacc), .sys_osc_select(osc_sel),
        .sys_osc_enable(osc_en), .failsafe_clock_monitor_active(fs_act),
        .low_power_rc_clock_run(rc_run), .wdt_clear(wclr),
        .main_regulator_standby(mstb), .flash_regulator_standby(fstb));

    core_model core (.ref_clk(ref_clk), .rst(rst), .cpu_clk_en(cpu_en), .cmd_go(go),
        .cmd_idle(idle), .irq_in(irq), .psave_valid(psv), .psave_idle(psi),
        .int_request(intr), .cpu_ticks(ticks));

    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
    endtask : tick

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        wb_req <= '{1'b1, 1'b1, w, a, 4'hF, d};
        do begin
            tick(1);
            k++;
        end while (wb_rsp.ack !== 1'b1 && k < 50);
        chk({31'h0, wb_rsp.ack}, 32'h1);
        q        = wb_rsp.dat;
        pclk_ack = {16'h0000, pclk};
        wb_req <= '0;
        tick(1);
    endtask : bus

    task automatic psave(input logic op);
        go   <= 1'b1;
        idle <= op;
        tick(1);
        go <= 1'b0;
        n = 0;
        while (cpu_en !== 1'b0 && n < 20) begin
            tick(1);
            n++;
        end
        tick(2);
    endtask : psave

    task automatic wait_cpu();
        n = 0;
        while (cpu_en !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
    endtask : wait_cpu

    task automatic t_reset();
        chk(pclk, PRESENT);
        chk(pacc, PRESENT);
        bus(0, 8'h14, 0);
        chk(q[7:0], 8'h80);
        bus(0, 8'h08, 0);
        chk(q, 32'h0);
        bus(0, 8'h3C, 0);
        chk(q, 32'h0);
    endtask : t_reset

    task automatic t_osc();
        bus(1, 8'h00, 32'h500);
        tick(2);
        chk(osc_sel, 3'h5);
        bus(0, 8'h00, 0);
        chk(q, 32'h5500);
        lock <= 1'b1;
        bus(1, 8'h00, 32'h200);
        lock <= 1'b0;
        bus(0, 8'h00, 0);
        chk(q, 32'h5500);
    endtask : t_osc

    task automatic t_idle();
        bus(1, 8'h10, 32'h1);
        wdt_en <= 1'b1;
        w0 = wclr_cnt;
        psave(1'b1);
        chk(cpu_en, 1'b0);
        chk(pclk, PRESENT & 16'hFFFE);
        chk({osc_en, rc_run}, 2'h3);
        chk(wclr_cnt - w0, 1);
        irq <= 1'b1;
        wait_cpu();
        // Interrupt register edge, five controller edges to cpu_en, plus the sampling edge
        chk({31'h0, n >= 5 && n <= 7}, 32'h1);
        irq <= 1'b0;
    endtask : t_idle

    task automatic t_sleep();
        bus(1, 8'h04, 32'h100);
        bus(1, 8'h00, 32'h300);
        wdt_en  <= 1'b0;
        failsafe_clock_monitor_en <= 1'b1;
        tick(2);
        w0 = wclr_cnt;
        psave(1'b0);
        chk(wclr_cnt - w0, 0);
        chk({cpu_en, osc_en, fs_act, rc_run}, 4'h0);
        chk(pclk, 16'h0000);
        chk({mstb, fstb}, 2'h1);
        wdt_en <= 1'b1;
        tick(2);
        chk(rc_run, 1'b1);
        wdt_to <= 1'b1;
        wait_cpu();
        chk({31'h0, n < 40}, 32'h1);
        wdt_to <= 1'b0;
        wdt_en <= 1'b0;
        chk(osc_sel, 3'h3);
    endtask : t_sleep

    task automatic t_coincide();
        irq <= 1'b1;
        psave(1'b1);
        chk(cpu_en, 1'b0);
        wait_cpu();
        chk({31'h0, n < 20}, 32'h1);
        irq <= 1'b0;
    endtask : t_coincide

    task automatic t_doze();
        bus(1, 8'h08, 32'h0800);
        bus(0, 8'h08, 0);
        chk(q, 32'h0);
        for (int d = 1; d < 8; d++) begin
            bus(1, 8'h08, d << 12);
            bus(1, 8'h08, (d << 12) | 32'h800);
            t0 = ticks;
            tick(128);
            chk(ticks - t0, 16'd128 >> d);
            chk(pclk, PRESENT);
            bus(1, 8'h08, 0);
        end
        bus(1, 8'h08, 32'h3800);
        bus(1, 8'h08, 32'h5800);
        bus(0, 8'h08, 0);
        chk(q, 32'h3800);
        irq <= 1'b1;
        tick(4);
        irq <= 1'b0;
        bus(0, 8'h08, 0);
        chk(q, 32'h3800);
        bus(1, 8'h08, 32'hB800);
        irq <= 1'b1;
        tick(4);
        irq <= 1'b0;
        bus(0, 8'h08, 0);
        chk(q, 32'hB000);
        t0 = ticks;
        tick(16);
        chk(ticks - t0, 16'd16);
    endtask : t_doze

    task automatic t_md();
        bus(1, 8'h0C, 32'h5);
        chk(pclk_ack, PRESENT);
        chk(pclk, PRESENT & 16'hFFFA);
        chk(pacc, PRESENT & 16'hFFFA);
        bus(1, 8'h0C, 32'h0);
        chk(pclk, PRESENT);
    endtask : t_md

    task automatic final_report();
        if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report

    initial begin
        tick(12);
        rst <= 1'b0;
        tick(2);
        t_reset();
        t_osc();
        t_idle();
        t_sleep();
        t_coincide();
        t_doze();
        t_md();
        final_report();
    end

    // Whole run needs about 1100 cycles
    initial begin
        tick(20000);
        error_cnt++;
        final_report();
    end
endmodule : power_saving_clock_controller_bench

`default_nettype wire
